// ==== hw/scmc_consts.svh ====
// register offsets, field positions, reset values and counts of the clock mode control block
`ifndef SCMC_CONSTS_SVH
`define SCMC_CONSTS_SVH

// apb byte offsets
`define SCMC_OFS_MODE        12'h000
`define SCMC_OFS_IRQ_STATUS  12'h004
`define SCMC_OFS_IRQ_MASK    12'h008
`define SCMC_OFS_STATE       12'h00C

// clock_mode_reg fields
`define SCMC_BIT_DIRECT      0
`define SCMC_BIT_IDLE_EN     1
`define SCMC_BIT_HIGH_RDY    2
`define SCMC_BIT_LOW_RDY     3
`define SCMC_BIT_FAST_WAKE   4
`define SCMC_SEL_LSB         5
`define SCMC_SEL_MSB         7
`define SCMC_MODE_RST        8'h03
`define SCMC_MODE_WMASK      8'hF3

// selection codes of the divider field
`define SCMC_SEL_LOW_A       3'h0
`define SCMC_SEL_LOW_B       3'h1

// interrupt status fields
`define SCMC_IRQ_HIGH_RDY    0
`define SCMC_IRQ_LOW_RDY     1
`define SCMC_IRQ_WAKE        2
`define SCMC_IRQ_W           3

// oscillator settle counts, in oscillator cycles (upper end of each range)
`define SCMC_XTAL_CNT        11'h400
`define SCMC_HIGH_RC_CNT     11'h010
`define SCMC_LOW_RC_CNT      11'h002

`endif

// ==== hw/scmc_pkg.sv ====
// types of the clock mode control block
package scmc_pkg;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_IDLE_RUN,
    ST_IDLE_STOP,
    ST_SLEEP_LIGHT,
    ST_SLEEP_DEEP
  } scmc_state_t;

  typedef enum logic [1:0] {
    SRC_HIGH,
    SRC_HIGH_DIV,
    SRC_LOW,
    SRC_SUB
  } scmc_src_t;

endpackage

// ==== hw/scmc_osc_ready.sv ====
// settle counter that raises a ready flag once an oscillator has run long enough
`timescale 1ns/100ps
`default_nettype none
`include "scmc_consts.svh"

module scmc_osc_ready #(
  parameter logic [10:0] SHORT_CNT = 11'h010
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // oscillator
  input  wire logic osc_run,
  input  wire logic osc_tick,
  input  wire logic is_crystal,
  // status
  output logic      ready
);

  logic [10:0] cnt_q;
  logic [10:0] target;
  logic        ready_q;

  assign target = is_crystal ? `SCMC_XTAL_CNT : SHORT_CNT;
  assign ready  = ready_q;

  // a stopped oscillator forgets its settle progress
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 11'h000;
    end else if (!osc_run) begin
      cnt_q <= 11'h000;
    end else if (osc_tick && !ready_q) begin
      cnt_q <= cnt_q + 11'h001;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_q <= 1'b0;
    end else if (!osc_run) begin
      ready_q <= 1'b0;
    end else if (osc_tick && (cnt_q + 11'h001 == target)) begin
      ready_q <= 1'b1;
    end
  end

  a_ready_off: assert property (@(posedge clk) disable iff (!arst_n)
    !osc_run |=> !ready_q)
    else $error("ready flag set while oscillator stopped");

  a_ready_count: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(ready_q) |-> cnt_q == target)
    else $error("ready flag rose before settle count reached");

endmodule
`default_nettype wire

// ==== hw/scmc_clock_mode_ctrl.sv ====
// clock source selection, halt mode control and oscillator ready flags with apb registers
`timescale 1ns/100ps
`default_nettype none
`include "scmc_consts.svh"

module scmc_clock_mode_ctrl (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // core and wake sources
  input  wire logic        halt_req,
  input  wire logic        wake_req,
  input  wire logic        idle_sysclk_keepalive,
  input  wire logic        sub_keep_on,
  input  wire logic        wdt_src_sub,
  // oscillator configuration and ticks
  input  wire logic        high_crystal_osc,
  input  wire logic        low_crystal_osc,
  input  wire logic        high_osc_tick,
  input  wire logic        low_osc_tick,
  // clock controls
  output logic             high_osc_en,
  output logic             low_osc_en,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             wdt_clk_en,
  output scmc_pkg::scmc_src_t sysclk_src,
  output logic [2:0]       sysclk_div_select,
  output logic             clock_running_idle,
  output logic             deep_sleep,
  // interrupt
  output logic             irq
);

  scmc_pkg::scmc_state_t state_q;
  scmc_pkg::scmc_state_t state_d;
  scmc_pkg::scmc_src_t   src_d;
  scmc_pkg::scmc_src_t   src_q;

  logic [2:0]  sel_q;
  logic        fast_en_q;
  logic        idle_en_q;
  logic        direct_q;
  logic        fast_wake_q;
  logic        high_rdy;
  logic        low_rdy;
  logic        high_rdy_q;
  logic        low_rdy_q;
  logic        need_high;
  logic        running;
  logic        wake_ev;
  logic [7:0]  mode_rd;
  logic [`SCMC_IRQ_W-1:0] irq_sts_q;
  logic [`SCMC_IRQ_W-1:0] irq_msk_q;
  logic [`SCMC_IRQ_W-1:0] irq_set;
  logic [31:0] rd_d;
  logic        err_d;
  logic        wr_en;
  logic        setup;
  localparam logic [7:0] MODE_RST = `SCMC_MODE_RST;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;

  // register file
  assign mode_rd = {sel_q, fast_en_q, low_rdy, high_rdy, idle_en_q, direct_q};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_q     <= MODE_RST[`SCMC_SEL_MSB:`SCMC_SEL_LSB];
      fast_en_q <= MODE_RST[`SCMC_BIT_FAST_WAKE];
      idle_en_q <= MODE_RST[`SCMC_BIT_IDLE_EN];
      direct_q  <= MODE_RST[`SCMC_BIT_DIRECT];
    end else if (wr_en && paddr == `SCMC_OFS_MODE) begin
      // ready flag positions are not stored; they always mirror hardware
      sel_q     <= pwdata[`SCMC_SEL_MSB:`SCMC_SEL_LSB];
      fast_en_q <= pwdata[`SCMC_BIT_FAST_WAKE];
      idle_en_q <= pwdata[`SCMC_BIT_IDLE_EN];
      direct_q  <= pwdata[`SCMC_BIT_DIRECT];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_msk_q <= '0;
    end else if (wr_en && paddr == `SCMC_OFS_IRQ_MASK) begin
      irq_msk_q <= pwdata[`SCMC_IRQ_W-1:0];
    end
  end

  // set wins over a simultaneous write-one clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_sts_q <= '0;
    end else if (wr_en && paddr == `SCMC_OFS_IRQ_STATUS) begin
      irq_sts_q <= (irq_sts_q & ~pwdata[`SCMC_IRQ_W-1:0]) | irq_set;
    end else begin
      irq_sts_q <= irq_sts_q | irq_set;
    end
  end

  assign irq = |(irq_sts_q & irq_msk_q);

  always_comb begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    unique case (paddr)
      `SCMC_OFS_MODE:       rd_d[7:0] = mode_rd;
      `SCMC_OFS_IRQ_STATUS: rd_d[`SCMC_IRQ_W-1:0] = irq_sts_q;
      `SCMC_OFS_IRQ_MASK:   rd_d[`SCMC_IRQ_W-1:0] = irq_msk_q;
      `SCMC_OFS_STATE:      rd_d[4:0] = {src_q, state_q};
      default:              err_d = 1'b1;
    endcase
  end

  // read data is fetched in the setup cycle so the access phase answers at once
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= rd_d;
      pslverr <= err_d;
    end
  end

  // operating mode
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      scmc_pkg::ST_RUN: begin
        if (halt_req) begin
          if (idle_en_q) begin
            state_d = idle_sysclk_keepalive ? scmc_pkg::ST_IDLE_RUN : scmc_pkg::ST_IDLE_STOP;
          end else begin
            state_d = sub_keep_on ? scmc_pkg::ST_SLEEP_LIGHT : scmc_pkg::ST_SLEEP_DEEP;
          end
        end
      end
      scmc_pkg::ST_IDLE_RUN,
      scmc_pkg::ST_IDLE_STOP,
      scmc_pkg::ST_SLEEP_LIGHT,
      scmc_pkg::ST_SLEEP_DEEP: begin
        if (wake_req) begin
          state_d = scmc_pkg::ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= scmc_pkg::ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  assign wake_ev = (state_q != scmc_pkg::ST_RUN) && wake_req;

  // fast wake-up only helps when the substitute clock was kept alive
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fast_wake_q <= 1'b0;
    end else if (wake_ev) begin
      fast_wake_q <= fast_en_q && high_crystal_osc && need_high &&
                     (state_q == scmc_pkg::ST_IDLE_STOP || state_q == scmc_pkg::ST_SLEEP_LIGHT);
    end else if (high_rdy) begin
      fast_wake_q <= 1'b0;
    end
  end

  // clock gating
  assign need_high = direct_q || (sel_q != `SCMC_SEL_LOW_A && sel_q != `SCMC_SEL_LOW_B);
  assign running   = state_q == scmc_pkg::ST_RUN || state_q == scmc_pkg::ST_IDLE_RUN;

  assign high_osc_en        = running && need_high;
  assign low_osc_en         = state_q != scmc_pkg::ST_SLEEP_DEEP;
  assign cpu_clk_en         = state_q == scmc_pkg::ST_RUN;
  assign periph_clk_en      = running;
  assign clock_running_idle = state_q == scmc_pkg::ST_IDLE_RUN;
  assign deep_sleep         = state_q == scmc_pkg::ST_SLEEP_DEEP;

  always_comb begin
    wdt_clk_en = 1'b0;
    unique case (state_q)
      scmc_pkg::ST_RUN,
      scmc_pkg::ST_IDLE_RUN:    wdt_clk_en = 1'b1;
      scmc_pkg::ST_IDLE_STOP,
      scmc_pkg::ST_SLEEP_LIGHT: wdt_clk_en = wdt_src_sub;
      scmc_pkg::ST_SLEEP_DEEP:  wdt_clk_en = 1'b0;
    endcase
  end

  always_comb begin
    if (fast_wake_q) begin
      src_d = scmc_pkg::SRC_SUB;
    end else if (direct_q) begin
      src_d = scmc_pkg::SRC_HIGH;
    end else if (!need_high) begin
      src_d = scmc_pkg::SRC_LOW;
    end else begin
      src_d = scmc_pkg::SRC_HIGH_DIV;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      src_q             <= scmc_pkg::SRC_HIGH;
      sysclk_div_select <= MODE_RST[`SCMC_SEL_MSB:`SCMC_SEL_LSB];
    end else begin
      src_q             <= src_d;
      sysclk_div_select <= sel_q;
    end
  end

  assign sysclk_src = src_q;

  // oscillator ready flags
  scmc_osc_ready #(
    .SHORT_CNT (`SCMC_HIGH_RC_CNT)
  ) u_high_ready (
    .clk        (clk),
    .arst_n     (arst_n),
    .osc_run    (high_osc_en),
    .osc_tick   (high_osc_tick),
    .is_crystal (high_crystal_osc),
    .ready      (high_rdy)
  );

  scmc_osc_ready #(
    .SHORT_CNT (`SCMC_LOW_RC_CNT)
  ) u_low_ready (
    .clk        (clk),
    .arst_n     (arst_n),
    .osc_run    (low_osc_en),
    .osc_tick   (low_osc_tick),
    .is_crystal (low_crystal_osc),
    .ready      (low_rdy)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      high_rdy_q <= 1'b0;
      low_rdy_q  <= 1'b0;
    end else begin
      high_rdy_q <= high_rdy;
      low_rdy_q  <= low_rdy;
    end
  end

  assign irq_set[`SCMC_IRQ_HIGH_RDY] = high_rdy && !high_rdy_q;
  assign irq_set[`SCMC_IRQ_LOW_RDY]  = low_rdy && !low_rdy_q;
  assign irq_set[`SCMC_IRQ_WAKE]     = wake_ev;

  // checks
  a_halt_idle_run: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == scmc_pkg::ST_RUN && halt_req && idle_en_q && idle_sysclk_keepalive
    |=> state_q == scmc_pkg::ST_IDLE_RUN && clock_running_idle)
    else $error("halt with idle and keepalive did not enter clock-running idle");

  a_idle_cpu_off: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == scmc_pkg::ST_IDLE_RUN |-> !cpu_clk_en && (high_osc_en == need_high) && low_osc_en)
    else $error("clock-running idle gated the wrong clocks");

  a_idle_periph: assert property (@(posedge clk) disable iff (!arst_n)
    clock_running_idle |-> periph_clk_en)
    else $error("peripheral clock stopped in clock-running idle");

  a_idle_wdt: assert property (@(posedge clk) disable iff (!arst_n)
    clock_running_idle |-> wdt_clk_en)
    else $error("watchdog clock stopped in clock-running idle");

  a_sel_low_src: assert property (@(posedge clk) disable iff (!arst_n)
    !direct_q && !fast_wake_q && (sel_q == `SCMC_SEL_LOW_A || sel_q == `SCMC_SEL_LOW_B)
    |-> !high_osc_en ##1 sysclk_src == scmc_pkg::SRC_LOW)
    else $error("low clock selection not applied");

  a_fast_sub: assert property (@(posedge clk) disable iff (!arst_n)
    fast_wake_q && !high_rdy |=> sysclk_src == scmc_pkg::SRC_SUB)
    else $error("fast wake-up did not run from substitute clock");

  a_low_deep: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == scmc_pkg::ST_SLEEP_DEEP ##1 state_q == scmc_pkg::ST_SLEEP_DEEP |-> !low_rdy)
    else $error("low ready flag high in deep sleep");

  a_high_bit: assert property (@(posedge clk) disable iff (!arst_n)
    setup && paddr == `SCMC_OFS_MODE |=> prdata[`SCMC_BIT_HIGH_RDY] == $past(high_rdy))
    else $error("bit 2 does not show the high ready flag");

  a_high_stop: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == scmc_pkg::ST_IDLE_STOP |=> !high_rdy)
    else $error("high ready flag held while oscillator stopped");

  a_halt_sleep: assert property (@(posedge clk) disable iff (!arst_n)
    state_q == scmc_pkg::ST_RUN && halt_req && !idle_en_q
    |=> state_q == scmc_pkg::ST_SLEEP_LIGHT || state_q == scmc_pkg::ST_SLEEP_DEEP)
    else $error("halt with idle disabled did not enter sleep");

  a_direct_high: assert property (@(posedge clk) disable iff (!arst_n)
    direct_q && !fast_wake_q |=> sysclk_src == scmc_pkg::SRC_HIGH)
    else $error("direct selection did not pick undivided high clock");

  a_rdy_nowrite: assert property (@(posedge clk) disable iff (!arst_n)
    wr_en && paddr == `SCMC_OFS_MODE |=> high_rdy == $past(high_rdy) || $past(high_osc_tick) || !$past(high_osc_en))
    else $error("software write changed the high ready flag");

endmodule
`default_nettype wire

// ==== verification/scmc_clock_mode_ctrl_tb_top.sv ====
// self-checking testbench of the clock mode control block
`timescale 1ns/100ps
`default_nettype none
`include "scmc_consts.svh"

module scmc_clock_mode_ctrl_tb_top;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        pready, pslverr, irq;
  logic [31:0] prdata;
  logic        halt_req = 1'b0, wake_req = 1'b0, keepalive = 1'b0, sub_keep_on = 1'b0, wdt_src_sub = 1'b0;
  logic        high_xtal = 1'b0, low_xtal = 1'b0, high_osc_tick = 1'b0, low_osc_tick = 1'b0;
  logic        high_osc_en, low_osc_en, cpu_clk_en, periph_clk_en, wdt_clk_en, clock_running_idle, deep_sleep;
  scmc_pkg::scmc_src_t sysclk_src;
  logic [2:0]  sysclk_div_select;
  logic [6:0]  clk_vec;
  logic [31:0] rd;
  logic        err;
  int          n_errors = 0;
  int          compares = 0;
  int          cycles = 0;

  // exp tables of the halt modes: mode value, keepalive, sub keep, wdt source, state, clock enables
  logic [7:0]  h_mode [4] = '{8'h03, 8'h03, 8'h01, 8'h01};
  logic [2:0]  h_lvl  [4] = '{3'b101, 3'b000, 3'b011, 3'b000};
  logic [2:0]  h_st   [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
  logic [6:0]  h_vec  [4] = '{7'b0111011, 7'b0000001, 7'b0010001, 7'b0000100};

  assign clk_vec = {cpu_clk_en, periph_clk_en, wdt_clk_en, clock_running_idle, deep_sleep, high_osc_en, low_osc_en};

  always #5 clk = ~clk;

  scmc_clock_mode_ctrl dut (
    .clk                   (clk),
    .arst_n                (arst_n),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .pready                (pready),
    .prdata                (prdata),
    .pslverr               (pslverr),
    .halt_req              (halt_req),
    .wake_req              (wake_req),
    .idle_sysclk_keepalive (keepalive),
    .sub_keep_on           (sub_keep_on),
    .wdt_src_sub           (wdt_src_sub),
    .high_crystal_osc      (high_xtal),
    .low_crystal_osc       (low_xtal),
    .high_osc_tick         (high_osc_tick),
    .low_osc_tick          (low_osc_tick),
    .high_osc_en           (high_osc_en),
    .low_osc_en            (low_osc_en),
    .cpu_clk_en            (cpu_clk_en),
    .periph_clk_en         (periph_clk_en),
    .wdt_clk_en            (wdt_clk_en),
    .sysclk_src            (sysclk_src),
    .sysclk_div_select     (sysclk_div_select),
    .clock_running_idle    (clock_running_idle),
    .deep_sleep            (deep_sleep),
    .irq                   (irq)
  );

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // generous ceiling: the crystal settle walks take about 2k cycles each
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("unexpected value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0000_0000);
    chk(exp, rd);
  endtask

  task automatic ticks(input logic high, input int n);
    repeat (n) begin
      @(posedge clk);
      if (high) begin
        high_osc_tick <= 1'b1;
      end else begin
        low_osc_tick <= 1'b1;
      end
      @(posedge clk);
      high_osc_tick <= 1'b0;
      low_osc_tick  <= 1'b0;
    end
  endtask

  // one-cycle pulse on halt (sel 0) or wake (sel 1), outputs settled afterwards
  task automatic pulse(input logic sel);
    @(posedge clk);
    if (sel) begin
      wake_req <= 1'b1;
    end else begin
      halt_req <= 1'b1;
    end
    @(posedge clk);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
    #1;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    // register reset values, read-only ready bits, unmapped address
    rd_chk(`SCMC_OFS_MODE, 32'h0000_0003);
    rd_chk(`SCMC_OFS_IRQ_STATUS, 32'h0000_0000);
    rd_chk(`SCMC_OFS_IRQ_MASK, 32'h0000_0000);
    apb(1'b1, `SCMC_OFS_MODE, 32'h0000_00FF);
    rd_chk(`SCMC_OFS_MODE, 32'h0000_00F3);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(32'h0000_0001, {31'h0, err});
    $display("test registers done");
    // every code of the select field with direct selection off
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, `SCMC_OFS_MODE, {24'h0, 3'(s), 5'h02});
      repeat (2) @(posedge clk);
      #1;
      chk(32'(s), 32'(sysclk_div_select));
      chk(32'((s < 2) ? scmc_pkg::SRC_LOW : scmc_pkg::SRC_HIGH_DIV), 32'(sysclk_src));
      chk(32'(s >= 2), 32'(high_osc_en));
    end
    apb(1'b1, `SCMC_OFS_MODE, 32'h0000_0003);
    repeat (2) @(posedge clk);
    #1;
    chk(32'(scmc_pkg::SRC_HIGH), 32'(sysclk_src));
    $display("test clock select done");
    // ready flags: rc high settles on tick 16, rc low on tick 2
    ticks(1'b1, 15);
    rd_chk(`SCMC_OFS_MODE, 32'h0000_0003);
    ticks(1'b1, 1);
    rd_chk(`SCMC_OFS_MODE, 32'h0000_0007);
    ticks(1'b0, 1);
    rd_chk(`SCMC_OFS_MODE, 32'h0000_0007);
    ticks(1'b0, 1);
    rd_chk(`SCMC_OFS_MODE, 32'h0000_000F);
    rd_chk(`SCMC_OFS_IRQ_STATUS, 32'h0000_0003);
    $display("test ready flags done");
    // interrupt: masked, unmasked, partial and full clear; a write lands at the closing edge, so settle first
    chk(32'h0, 32'(irq));
    apb(1'b1, `SCMC_OFS_IRQ_MASK, 32'h0000_0001);
    #1;
    chk(32'h1, 32'(irq));
    apb(1'b1, `SCMC_OFS_IRQ_STATUS, 32'h0000_0002);
    rd_chk(`SCMC_OFS_IRQ_STATUS, 32'h0000_0001);
    chk(32'h1, 32'(irq));
    apb(1'b1, `SCMC_OFS_IRQ_STATUS, 32'h0000_0001);
    #1;
    chk(32'h0, 32'(irq));
    apb(1'b1, `SCMC_OFS_IRQ_MASK, 32'h0000_0004);
    $display("test interrupt done");
    // each halt mode, then wake back to run
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `SCMC_OFS_MODE, {24'h0, h_mode[i]});
      keepalive   <= h_lvl[i][2];
      sub_keep_on <= h_lvl[i][1];
      wdt_src_sub <= h_lvl[i][0];
      pulse(1'b0);
      chk(32'(h_vec[i]), 32'(clk_vec));
      rd_chk(`SCMC_OFS_STATE, {27'h0, 2'(scmc_pkg::SRC_HIGH), h_st[i]});
      pulse(1'b1);
      chk(32'h0000_0073, 32'(clk_vec));
      chk(32'h1, 32'(irq));
      apb(1'b1, `SCMC_OFS_IRQ_STATUS, 32'h0000_0007);
      #1;
      chk(32'h0, 32'(irq));
    end
    // after deep sleep both flags start low and settle again
    rd_chk(`SCMC_OFS_MODE, 32'h0000_0001);
    ticks(1'b0, 2);
    rd_chk(`SCMC_OFS_MODE, 32'h0000_0009);
    ticks(1'b1, 16);
    rd_chk(`SCMC_OFS_MODE, 32'h0000_000D);
    $display("test halt modes done");
    // fast wake from clock-stopped idle with a high crystal; the low flag stays up through idle
    apb(1'b1, `SCMC_OFS_MODE, 32'h0000_0013);
    keepalive <= 1'b0;
    high_xtal <= 1'b1;
    pulse(1'b0);
    pulse(1'b1);
    @(posedge clk);
    #1;
    chk(32'(scmc_pkg::SRC_SUB), 32'(sysclk_src));
    ticks(1'b1, 1023);
    #1;
    chk(32'(scmc_pkg::SRC_SUB), 32'(sysclk_src));
    ticks(1'b1, 1);
    repeat (2) @(posedge clk);
    #1;
    chk(32'(scmc_pkg::SRC_HIGH), 32'(sysclk_src));
    rd_chk(`SCMC_OFS_MODE, 32'h0000_001F);
    $display("test fast wake done");
    // low crystal: deep sleep drops the low flag, which returns on low tick 1024
    apb(1'b1, `SCMC_OFS_MODE, 32'h0000_0001);
    low_xtal <= 1'b1;
    pulse(1'b0);
    chk(32'h1, 32'(deep_sleep));
    pulse(1'b1);
    ticks(1'b0, 1023);
    rd_chk(`SCMC_OFS_MODE, 32'h0000_0001);
    ticks(1'b0, 1);
    rd_chk(`SCMC_OFS_MODE, 32'h0000_0009);
    $display("test low crystal done");
    final_report();
  end
endmodule
`default_nettype wire
